// [core/acr_pkg.sv]
// Shared constants and types for the converter readout and power-down block.
// Assumes a 125 MHz system clock; the serial clock is a separate domain.
package acr_pkg;

    // ------------------------------------------------------------
    // Word and clock figures
    // ------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int CLK_PERIOD_PS = 8000;

    // ------------------------------------------------------------
    // Timing (least times round up to whole cycles)
    // ------------------------------------------------------------
    localparam int CONV_TIME_NS = 4000;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_CYCLES = 4;
    localparam int INT_HALF_NS = 40;
    localparam int INT_HALF_CYCLES = (INT_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int INT_EDGES = 2 * WORD_BITS;
    localparam int RECOVERY_TIME_US = 1000;
    localparam int RECOVERY_CYCLES = (RECOVERY_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int NULL_EDGE = WORD_BITS;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WORD_BITS-1:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Sequencer states, Gray coded along the conversion path
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_SETTLE = 2'b11,
        ST_CLOCKOUT = 2'b10
    } acr_state_type;

endpackage

// [core/acr_link_shift.sv]
// Serial output shifter, clocked by the serial data clock.
// Assumes the result word and its toggle are held stable for several system
// cycles before end of conversion rises, so they are read here as quasi-static.
`timescale 1ns/100ps
module acr_link_shift
    import acr_pkg::*;
(
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic [acr_pkg::WORD_BITS-1:0] word,
    input wire logic word_tgl,
    input wire logic ext_mode,
    input wire logic cascade_in,
    output logic data_out,
    output logic load_tgl
);
    logic [WORD_BITS-1:0] sreg;
    logic [WORD_BITS-1:0] next_sreg;
    logic next_data_out;
    logic next_load_tgl;
    logic fresh;
    logic tag;

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    assign fresh = (word_tgl != load_tgl);
    // Cascade input is ignored unless the serial clock comes from outside
    assign tag = ext_mode ? cascade_in : 1'b0;

    always_comb
    begin
        next_load_tgl = load_tgl;
        if (fresh)
        begin
            // MSB leaves on the first edge; the tag sampled on this same edge is
            // stale, which becomes the null bit sixteen edges later
            next_data_out = word[WORD_BITS-1];
            next_sreg = {word[WORD_BITS-2:0], tag};
            next_load_tgl = word_tgl;
        end
        else
        begin
            next_data_out = sreg[WORD_BITS-1];
            next_sreg = {sreg[WORD_BITS-2:0], tag};
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            sreg <= RESULT_RESET;
            data_out <= 1'b0;
            load_tgl <= 1'b0;
        end
        else
        begin
            sreg <= next_sreg;
            data_out <= next_data_out;
            load_tgl <= next_load_tgl;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [5:0] edge_cnt;
    logic null_cap;
    always_ff @(posedge link_clk)
    begin
        if (!rst_n)
        begin
            edge_cnt <= 6'h3f;
            null_cap <= 1'b0;
        end
        else if (fresh)
        begin
            edge_cnt <= 6'h01;
            null_cap <= tag;
        end
        else if (edge_cnt != 6'h3f)
        begin
            edge_cnt <= edge_cnt + 6'h01;
        end
    end

    load_msb_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        fresh |=> data_out == $past(word[WORD_BITS-1]))
        else $error("first edge did not present the result MSB");
    cascade_pass_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        (!fresh && ext_mode) |=> sreg[0] == $past(cascade_in))
        else $error("cascade bit not captured in external clock mode");
    tag_blocked_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        (!fresh && !ext_mode) |=> !sreg[0])
        else $error("cascade input used in internal clock mode");
    null_bit_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        (edge_cnt == 6'(NULL_EDGE) && !fresh) |=> data_out == null_cap)
        else $error("null bit missing after sixteen result bits");
    word_order_a: assert property (@(posedge link_clk) disable iff (!rst_n)
        fresh ##1 !fresh |=> data_out == $past(word[WORD_BITS-2], 2))
        else $error("second result bit out of order");

endmodule // acr_link_shift

// [core/acr_readout.sv]
// Converter digital core: conversion sequencing, power-down and serial readout.
// Assumes an analog model supplies SAMPLE_CODE on SYS_CLK and the host (or the
// internal clock loopback) drives SERIAL_DATA_CLOCK.
`timescale 1ns/100ps
module acr_readout
    import acr_pkg::*;
#(
    parameter int RECOVERY_CYCLES_P = acr_pkg::RECOVERY_CYCLES
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic READ_CONVERT_N,
    input wire logic CHIP_SELECT_N,
    input wire logic CLOCK_SOURCE_SELECT,
    input wire logic POWER_DOWN_PIN,
    input wire logic [acr_pkg::WORD_BITS-1:0] SAMPLE_CODE,
    input wire logic SERIAL_DATA_CLOCK,
    input wire logic CASCADE_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OE,
    output logic SERIAL_CLOCK_OUT,
    output logic SERIAL_CLOCK_OE,
    output logic END_OF_CONVERSION,
    output logic ANALOG_ENABLE,
    output logic POWER_SETTLED,
    output logic RESULT_UNREAD
);
    import acr_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic rc_s1, rc_s2, cs_s1, cs_s2, ext_s1, ext_s2, pd_s1, pd_s2, ack_s1, ack_s2;
    logic rc_prev;
    logic load_tgl;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            {rc_s1, rc_s2, rc_prev} <= 3'h7;
            {cs_s1, cs_s2} <= 2'h3;
            // Reset to the external setting so the clock pin is never driven
            // against the host while the select pin works its way through
            {ext_s1, ext_s2} <= 2'h3;
            {pd_s1, pd_s2} <= 2'h0;
            {ack_s1, ack_s2} <= 2'h0;
        end
        else if (CLK_EN)
        begin
            rc_s1 <= READ_CONVERT_N;
            rc_s2 <= rc_s1;
            rc_prev <= rc_s2;
            cs_s1 <= CHIP_SELECT_N;
            cs_s2 <= cs_s1;
            ext_s1 <= CLOCK_SOURCE_SELECT;
            ext_s2 <= ext_s1;
            pd_s1 <= POWER_DOWN_PIN;
            pd_s2 <= pd_s1;
            ack_s1 <= load_tgl;
            ack_s2 <= ack_s1;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    acr_state_type state, next_state;
    logic [15:0] count, next_count;
    logic [5:0] edges, next_edges;
    logic [WORD_BITS-1:0] sample, next_sample;
    logic [WORD_BITS-1:0] result, next_result;
    logic word_tgl, next_word_tgl;
    logic eoc, next_eoc;
    logic sclk, next_sclk;
    logic start_ok;

    // Every chained part sees the same line through the same two flops, so
    // all of them latch their sample on the same cycle
    assign start_ok = rc_prev && !rc_s2 && !cs_s2 && !pd_s2;

    always_comb
    begin
        next_state = state;
        next_count = count;
        next_edges = edges;
        next_sample = sample;
        next_result = result;
        next_word_tgl = word_tgl;
        next_eoc = eoc;
        next_sclk = sclk;
        unique case (state)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    next_sample = SAMPLE_CODE;
                    next_eoc = 1'b0;
                    next_count = COUNT_RESET;
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                next_count = count + 16'h0001;
                if (count == 16'(CONV_CYCLES - 1))
                begin
                    // Publish the word first; EOC follows after the settle gap
                    next_result = sample;
                    next_word_tgl = !word_tgl;
                    next_count = COUNT_RESET;
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                next_count = count + 16'h0001;
                if (count == 16'(SETTLE_CYCLES - 1))
                begin
                    next_eoc = 1'b1;
                    next_count = COUNT_RESET;
                    next_edges = 6'h00;
                    next_state = ext_s2 ? ST_IDLE : ST_CLOCKOUT;
                end
            end
            ST_CLOCKOUT:
            begin
                // Internal clock mode: sixteen pulses, idling low at the end
                next_count = count + 16'h0001;
                if (count == 16'(INT_HALF_CYCLES - 1))
                begin
                    next_count = COUNT_RESET;
                    next_sclk = !sclk;
                    next_edges = edges + 6'h01;
                    if (edges == 6'(INT_EDGES - 1))
                    begin
                        next_state = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            state <= ST_IDLE;
            count <= COUNT_RESET;
            edges <= 6'h00;
            sample <= RESULT_RESET;
            result <= RESULT_RESET;
            word_tgl <= 1'b0;
            eoc <= 1'b1;
            sclk <= 1'b0;
        end
        else if (CLK_EN)
        begin
            state <= next_state;
            count <= next_count;
            edges <= next_edges;
            sample <= next_sample;
            result <= next_result;
            word_tgl <= next_word_tgl;
            eoc <= next_eoc;
            sclk <= next_sclk;
        end
    end

    // ------------------------------------------------------------
    // Power control and status
    // ------------------------------------------------------------
    logic [31:0] recover, next_recover;
    logic analog_on, next_analog_on;
    logic data_oe, next_data_oe;
    logic clk_oe, next_clk_oe;

    always_comb
    begin
        next_analog_on = !pd_s2;
        next_data_oe = !cs_s2;
        next_clk_oe = !ext_s2;
        next_recover = recover;
        if (pd_s2)
        begin
            next_recover = 32'(RECOVERY_CYCLES_P);
        end
        else if (recover != 32'h0)
        begin
            next_recover = recover - 32'h1;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            recover <= 32'h0;
            analog_on <= 1'b1;
            data_oe <= 1'b0;
            clk_oe <= 1'b0;
        end
        else if (CLK_EN)
        begin
            recover <= next_recover;
            analog_on <= next_analog_on;
            data_oe <= next_data_oe;
            clk_oe <= next_clk_oe;
        end
    end

    assign END_OF_CONVERSION = eoc;
    assign ANALOG_ENABLE = analog_on;
    assign POWER_SETTLED = (recover == 32'h0);
    assign SERIAL_DATA_OE = data_oe;
    assign SERIAL_CLOCK_OE = clk_oe;
    assign SERIAL_CLOCK_OUT = sclk;
    // Unread until the link domain has taken the word onto the wire
    assign RESULT_UNREAD = (word_tgl != ack_s2);

    // ------------------------------------------------------------
    // Serial link side
    // ------------------------------------------------------------
    acr_link_shift acr_link_shift_i (
        .link_clk(SERIAL_DATA_CLOCK),
        .rst_n(RST_N),
        .word(result),
        .word_tgl(word_tgl),
        .ext_mode(ext_s2),
        .cascade_in(CASCADE_IN),
        .data_out(SERIAL_DATA_OUT),
        .load_tgl(load_tgl)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    eoc_busy_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        state == ST_CONVERT |-> !eoc)
        else $error("end of conversion high during conversion");
    eoc_result_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(eoc) |-> RESULT_UNREAD && result == sample)
        else $error("end of conversion rose without a fresh result");
    sample_take_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_IDLE && start_ok && CLK_EN) |=> sample == $past(SAMPLE_CODE) && !eoc)
        else $error("sample not latched on convert edge");
    pd_refuse_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_IDLE && pd_s2) |=> state == ST_IDLE)
        else $error("conversion started while powered down");
    pd_analog_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (pd_s2 && CLK_EN) |=> !ANALOG_ENABLE)
        else $error("analog section left on in power-down");
    pd_keep_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (pd_s2 && state == ST_IDLE) |=> $stable(result) && $stable(word_tgl))
        else $error("result lost during power-down");
    clock_master_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (CLK_EN && !ext_s2) |=> SERIAL_CLOCK_OE)
        else $error("internal mode without serial clock drive");
    conv_length_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (state == ST_CONVERT && count == 16'(CONV_CYCLES - 1) && CLK_EN) |=> state == ST_SETTLE)
        else $error("conversion length wrong");

endmodule // acr_readout

// [tb/acr_host_model.sv]
// Host stand-in: makes bursts of the serial data clock and plays the upstream converter on the cascade input.
// Assumes the bench starts each burst only once end of conversion is high.
`timescale 1ns/100ps
module acr_host_model (
    input wire logic start,
    input wire logic [5:0] n_pulses,
    input wire logic [15:0] up_word,
    input wire logic cascade_en,
    input wire logic no_null,
    input wire logic tie_level,
    input wire logic link_wire,
    input wire logic data_in,
    output logic link_clk,
    output logic cascade,
    output logic busy,
    output logic [33:0] bits
);
    initial
    begin
        link_clk = 1'b0;
        cascade = 1'b0;
        busy = 1'b0;
        bits = '0;
    end
    // ------------------------------------------------------------
    // Burst generator
    // ------------------------------------------------------------
    // Clock idles low and runs only inside a burst; 48 ns period
    always @(posedge start)
    begin : burst
        int k;
        busy = 1'b1;
        bits = '0;
        // Odd offset keeps the link edges apart from the system clock edges
        #5.3;
        // With no_null, an upstream convert delayed one link clock puts its MSB out before the first edge; otherwise its inverted MSB is out
        cascade = cascade_en ? (no_null ? up_word[15] : ~up_word[15]) : tie_level;
        for (k = 0; k < n_pulses; k++)
        begin
            link_clk = 1'b1;
            #2;
            // Upstream output moves after each edge; past its word it keeps changing
            if (cascade_en)
                cascade = (k + int'(no_null) < 16) ? up_word[15 - k - int'(no_null)] : ~cascade;
            #22;
            link_clk = 1'b0;
            #24;
        end
        busy = 1'b0;
    end
    // ------------------------------------------------------------
    // Receiver: data is settled by the falling edge
    // ------------------------------------------------------------
    always @(negedge link_wire)
        bits = {bits[32:0], data_in};
endmodule // acr_host_model

// [tb/adc_cascade_readout_powerdown_tb_top.sv]
// Self-checking bench for the converter readout: conversion timing, cascaded read, internal clock, power-down.
// Assumes a 125 MHz system clock and the host model of acr_host_model on the serial side.
`timescale 1ns/100ps
module adc_cascade_readout_powerdown_tb_top;
    import acr_pkg::*;
    logic SYS_CLK = 1'b0, RST_N = 1'b0, CLK_EN = 1'b1, READ_CONVERT_N = 1'b1, CHIP_SELECT_N = 1'b0;
    logic CLOCK_SOURCE_SELECT = 1'b1, POWER_DOWN_PIN = 1'b0;
    logic [15:0] SAMPLE_CODE = 16'h0000;
    logic SERIAL_DATA_OUT, SERIAL_DATA_OE, SERIAL_CLOCK_OUT, SERIAL_CLOCK_OE, END_OF_CONVERSION;
    logic ANALOG_ENABLE, POWER_SETTLED, RESULT_UNREAD, host_clk, cascade, busy, start = 1'b0;
    logic cascade_en = 1'b0, no_null = 1'b0, link_wire;
    logic [5:0] n_pulses = 6'h01;
    logic [15:0] up_word = 16'h0000;
    logic [33:0] bits;
    int fails = 0, num_checks = 0;
    // Internal mode loops the device's own clock back onto its clock pin
    assign link_wire = CLOCK_SOURCE_SELECT ? host_clk : SERIAL_CLOCK_OUT;
    always #4 SYS_CLK = ~SYS_CLK;
    acr_readout #(.RECOVERY_CYCLES_P(20)) acr_readout_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
        .READ_CONVERT_N(READ_CONVERT_N), .CHIP_SELECT_N(CHIP_SELECT_N), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
        .POWER_DOWN_PIN(POWER_DOWN_PIN), .SAMPLE_CODE(SAMPLE_CODE), .SERIAL_DATA_CLOCK(link_wire),
        .CASCADE_IN(cascade), .SERIAL_DATA_OUT(SERIAL_DATA_OUT), .SERIAL_DATA_OE(SERIAL_DATA_OE),
        .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT), .SERIAL_CLOCK_OE(SERIAL_CLOCK_OE),
        .END_OF_CONVERSION(END_OF_CONVERSION), .ANALOG_ENABLE(ANALOG_ENABLE), .POWER_SETTLED(POWER_SETTLED),
        .RESULT_UNREAD(RESULT_UNREAD));
    acr_host_model acr_host_model_i (.start(start), .n_pulses(n_pulses), .up_word(up_word),
        .cascade_en(cascade_en), .no_null(no_null), .tie_level(1'b1), .link_wire(link_wire),
        .data_in(SERIAL_DATA_OUT),
        .link_clk(host_clk), .cascade(cascade), .busy(busy), .bits(bits));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask
    // Counts cycles until the signal shows the level; running out ends the run
    task automatic wait_for(ref logic sig, input logic level, input int max, output int n);
        n = 0;
        while (sig !== level)
        begin
            tick(1);
            n++;
            if (n > max)
            begin
                fails++;
                $display("ERROR t=%0t got=%h exp=%h", $time, sig, level);
                close_out();
            end
        end
    endtask
    task automatic conv(input logic [15:0] code);
        int n;
        SAMPLE_CODE = code;
        READ_CONVERT_N = 1'b0;
        wait_for(END_OF_CONVERSION, 1'b0, 10, n);
        READ_CONVERT_N = 1'b1;
        wait_for(END_OF_CONVERSION, 1'b1, 600, n);
        chk(n >= 503 && n <= 505, 1);
        chk(RESULT_UNREAD, 1);
    endtask
    task automatic rd(input logic [5:0] np, input logic [15:0] up, input logic en);
        int n;
        n_pulses = np;
        up_word = up;
        cascade_en = en;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        wait_for(busy, 1'b0, 2000, n);
        tick(5);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_cascade;
        conv(16'h8e35);
        rd(6'd34, 16'h5ac3, 1'b1);
        chk(bits[33:18], 16'h8e35);
        chk(bits[17], 1);
        chk(bits[16:1], 16'h5ac3);
        chk(RESULT_UNREAD, 0);
        conv(16'h0001);
        rd(6'd34, 16'hffff, 1'b1);
        chk(bits[33:18], 16'h0001);
        chk(bits[16:1], 16'hffff);
        no_null = 1'b1;
        conv(16'h7e81);
        rd(6'd34, 16'h9c3d, 1'b1);
        chk(bits[33:18], 16'h7e81);
        chk(bits[17:2], 16'h9c3d);
        no_null = 1'b0;
    endtask
    task automatic t_internal;
        int n, pulses;
        logic prev;
        CLOCK_SOURCE_SELECT = 1'b0;
        tick(6);
        chk(SERIAL_CLOCK_OE, 1);
        conv(16'hc3a7);
        pulses = 0;
        prev = 1'b0;
        for (n = 0; n < 400; n++)
        begin
            tick(1);
            if (SERIAL_CLOCK_OUT === 1'b1 && prev === 1'b0)
                pulses++;
            prev = SERIAL_CLOCK_OUT;
        end
        chk(pulses, 16);
        chk(bits[15:0], 16'hc3a7);
        CLOCK_SOURCE_SELECT = 1'b1;
        tick(6);
        chk(SERIAL_CLOCK_OE, 0);
    endtask
    task automatic t_power;
        int n;
        conv(16'h2d96);
        POWER_DOWN_PIN = 1'b1;
        tick(6);
        chk(ANALOG_ENABLE, 0);
        READ_CONVERT_N = 1'b0;
        tick(12);
        chk(END_OF_CONVERSION, 1);
        READ_CONVERT_N = 1'b1;
        tick(4);
        chk(RESULT_UNREAD, 1);
        rd(6'd16, 16'h0000, 1'b0);
        chk(bits[15:0], 16'h2d96);
        POWER_DOWN_PIN = 1'b0;
        wait_for(POWER_SETTLED, 1'b1, 60, n);
        chk(n >= 18 && n <= 26, 1);
        chk(ANALOG_ENABLE, 1);
    endtask
    task automatic t_select;
        CHIP_SELECT_N = 1'b1;
        tick(6);
        chk(SERIAL_DATA_OE, 0);
        READ_CONVERT_N = 1'b0;
        tick(12);
        chk(END_OF_CONVERSION, 1);
        READ_CONVERT_N = 1'b1;
        CHIP_SELECT_N = 1'b0;
        tick(6);
        chk(SERIAL_DATA_OE, 1);
        // Enable low must freeze the power-down synchroniser and status
        CLK_EN = 1'b0;
        POWER_DOWN_PIN = 1'b1;
        tick(6);
        chk(ANALOG_ENABLE, 1);
        CLK_EN = 1'b1;
        tick(6);
        chk(ANALOG_ENABLE, 0);
        POWER_DOWN_PIN = 1'b0;
    endtask
    initial
    begin
        tick(1);
        rd(6'd1, 16'h0000, 1'b0);
        chk({END_OF_CONVERSION, ANALOG_ENABLE, POWER_SETTLED, RESULT_UNREAD, SERIAL_DATA_OE}, 5'h1c);
        chk({SERIAL_CLOCK_OE, SERIAL_CLOCK_OUT, SERIAL_DATA_OUT}, 3'h0);
        RST_N = 1'b1;
        tick(8);
        t_cascade();
        t_internal();
        t_power();
        t_select();
        close_out();
    end
endmodule // adc_cascade_readout_powerdown_tb_top
